// File: hw/pdw_params.svh
// Constants for the power-down wake and clock select block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef PDW_PARAMS_SVH
`define PDW_PARAMS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define PDW_IDX_MEM_TIMING  16'hFE33
`define PDW_IDX_MISC_CLK    16'hFE81
`define PDW_IDX_PWD_SEL     16'hFF62
`define PDW_IDX_PWR_CTRL    16'hFF10
`define PDW_IDX_IRQ_CFG     16'hFF11
`define PDW_IDX_MAP_CTRL    16'hFF12
`define PDW_IDX_STATUS      16'hFF13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDW_CLKSEL_BIT      0
`define PDW_PD_BIT          1
`define PDW_SEL_BUSCLK      0
`define PDW_SEL_LOGICCLK    1
`define PDW_SEL_GBUF        2
`define PDW_SEL_RING        3
`define PDW_SEL_CRYSTAL     4
`define PDW_SEL_PIO         5
`define PDW_MAP_WIN_BIT     0
`define PDW_IRQ_EN_A        0
`define PDW_IRQ_EN_B        1
`define PDW_IRQ_GLOBAL      2
`define PDW_IRQ_LEVEL_A     3
`define PDW_IRQ_LEVEL_B     4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDW_RST_MEM_TIMING  8'h00
`define PDW_RST_MISC_CLK    8'h00
`define PDW_RST_PWD_SEL     8'h00
`define PDW_RST_PWR_CTRL    8'h00
`define PDW_RST_MAP_CTRL    8'h01
`define PDW_RST_IRQ_CFG     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PDW_CLK_PERIOD_NS   20
`define PDW_INIT_TIME_NS    2000
`define PDW_INIT_CYCLES     ((`PDW_INIT_TIME_NS + `PDW_CLK_PERIOD_NS - 1) / `PDW_CLK_PERIOD_NS)

`endif

// File: hw/pdw_pkg.sv
// Types for the power-down wake and clock select block
`default_nettype none

package pdw_pkg;

   typedef enum logic [2:0] {
      PDW_RUN  = 3'b000,
      PDW_DOWN = 3'b001,
      PDW_WAKE = 3'b010,
      PDW_INIT = 3'b011
   } pdw_state_t;

   typedef struct packed {
      pdw_state_t  st;
      logic [15:0] initCnt;
      logic [7:0]  memoryInterfaceTimingControl;
      logic [7:0]  miscClockSelectConfig;
      logic [7:0]  powerControlRegister;
      logic [7:0]  powerDownSelectRegister;
      logic [7:0]  configWindowMapControl;
      logic [7:0]  irqConfig;
      logic        crystalBlocked;
      logic [1:0]  wakeSrc;
      logic [31:0] rdData;
      logic        rdErr;
      logic        cpuRestart;
      logic [1:0]  wakeIrq;
   } pdw_ctrl_t;

   typedef struct packed {
      logic clkLvl;
      logic useCrystal;
   } pdw_switch_t;

endpackage

`default_nettype wire

// File: hw/pdw_clk_switch.sv
// Glitch-free bus clock source switch
`default_nettype none

module pdw_clk_switch
   import pdw_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic ringTick,
   input  wire logic crystalTick,
   input  wire logic selCrystal,
   input  wire logic freeze,
   output logic      busClk,
   output logic      onCrystal
);
   import pdw_pkg::*;

   pdw_switch_t s_reg;
   pdw_switch_t s_next;
   logic        tick;
   logic        swap;

   assign tick = s_reg.useCrystal ? crystalTick : ringTick;
   // Swap only where the old high phase would end: pulse only grows
   assign swap = s_reg.clkLvl && tick && (selCrystal != s_reg.useCrystal);

   always_comb begin
      s_next = s_reg;
      if (swap) begin
         s_next.useCrystal = selCrystal;
      end else if (tick) begin
         if (!s_reg.clkLvl) begin
            s_next.clkLvl = 1'b1;
         end else if (!freeze) begin
            s_next.clkLvl = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_reg <= '{clkLvl: 1'b1, useCrystal: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign busClk    = s_reg.clkLvl;
   assign onCrystal = s_reg.useCrystal;

   swapHigh_a: assert property (@(posedge clk_sys) disable iff (reset)
      swap |=> busClk && (onCrystal == $past(selCrystal)))
      else $error("clock swap truncated the high phase");

endmodule // pdw_clk_switch

`default_nettype wire

// File: hw/pdw_power_ctrl.sv
// Power-down wake sequencer, clock select and register slave
//
// Local design decision: the APB slave port.
`include "pdw_params.svh"
`default_nettype none

module pdw_power_ctrl
   import pdw_pkg::*;
#(
   parameter int INIT_CYCLES = `PDW_INIT_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [17:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        extResetN,
   input  wire logic        porFail,
   input  wire logic        watchdogReset,
   input  wire logic        appReset,
   input  wire logic        extIrqA,
   input  wire logic        extIrqB,
   input  wire logic        ringTick,
   input  wire logic        crystalTick,
   input  wire logic        initCrystalSel,
   output logic             busClk,
   output logic             busOnCrystal,
   output logic             ringOscEn,
   output logic             crystalOscEn,
   output logic             logicClkBlock,
   output logic             gbufPowerDown,
   output logic             pioPowerDown,
   output logic [7:0]       memTiming,
   output logic             cpuHalt,
   output logic             cpuRestart,
   output logic             wakeIrqA,
   output logic             wakeIrqB,
   output logic             initBusy
);
   import pdw_pkg::*;

   // ----------------------------------------------------------------
   // State and reset value
   // ----------------------------------------------------------------
   localparam pdw_ctrl_t RESET_VAL = '{
      st:                           PDW_INIT,
      initCnt:                      16'(INIT_CYCLES),
      memoryInterfaceTimingControl: `PDW_RST_MEM_TIMING,
      miscClockSelectConfig:        `PDW_RST_MISC_CLK,
      powerControlRegister:         `PDW_RST_PWR_CTRL,
      powerDownSelectRegister:      `PDW_RST_PWD_SEL,
      configWindowMapControl:       `PDW_RST_MAP_CTRL,
      irqConfig:                    `PDW_RST_IRQ_CFG,
      crystalBlocked:               1'b0,
      wakeSrc:                      2'b00,
      rdData:                       32'h0000_0000,
      rdErr:                        1'b0,
      cpuRestart:                   1'b0,
      wakeIrq:                      2'b00
   };

   pdw_ctrl_t   s_reg;
   pdw_ctrl_t   s_next;
   logic [15:0] regIdx;
   logic        apbWrite;
   logic        qualA;
   logic        qualB;
   logic        wakeAny;
   logic        pdBlock;
   logic        hardReset;
   logic        onCrystal;

   // ----------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------
   function automatic logic [32:0] readReg(input logic [15:0] idx, input pdw_ctrl_t s, input logic onXtal);
      logic [32:0] r;
      logic        winClosed;
      r         = 33'h0_0000_0000;
      winClosed = s.configWindowMapControl[`PDW_MAP_WIN_BIT];
      case (idx)
         `PDW_IDX_MEM_TIMING: r = winClosed ? {1'b1, 32'h0000_0000}
                                            : {25'h000_0000, s.memoryInterfaceTimingControl};
         `PDW_IDX_MISC_CLK:   r = winClosed ? {1'b1, 32'h0000_0000}
                                            : {25'h000_0000, s.miscClockSelectConfig};
         `PDW_IDX_PWD_SEL:    r = {25'h000_0000, s.powerDownSelectRegister};
         `PDW_IDX_PWR_CTRL:   r = {25'h000_0000, s.powerControlRegister};
         `PDW_IDX_IRQ_CFG:    r = {25'h000_0000, s.irqConfig};
         `PDW_IDX_MAP_CTRL:   r = {25'h000_0000, s.configWindowMapControl};
         `PDW_IDX_STATUS:     r = {25'h000_0000, (s.st == PDW_INIT), s.wakeSrc, onXtal, s.crystalBlocked, s.st};
         default:             r = {1'b1, 32'h0000_0000};
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Wake qualification and blocking
   // ----------------------------------------------------------------
   assign regIdx    = paddr[17:2];
   assign apbWrite  = psel && penable && pwrite;
   assign qualA     = extIrqA && s_reg.irqConfig[`PDW_IRQ_EN_A] && s_reg.irqConfig[`PDW_IRQ_GLOBAL]
                      && s_reg.irqConfig[`PDW_IRQ_LEVEL_A];
   assign qualB     = extIrqB && s_reg.irqConfig[`PDW_IRQ_EN_B] && s_reg.irqConfig[`PDW_IRQ_GLOBAL]
                      && s_reg.irqConfig[`PDW_IRQ_LEVEL_B];
   assign wakeAny   = qualA || qualB;
   // Blocking lifts in the same cycle a wake arrives
   assign pdBlock   = (s_reg.st == PDW_DOWN) && !wakeAny;
   assign hardReset = porFail || !extResetN;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next            = s_reg;
      s_next.cpuRestart = 1'b0;
      s_next.wakeIrq    = 2'b00;

      if (psel && !penable) begin
         {s_next.rdErr, s_next.rdData} = readReg(regIdx, s_reg, onCrystal);
      end
      if (apbWrite && !s_reg.rdErr) begin
         case (regIdx)
            `PDW_IDX_MEM_TIMING: s_next.memoryInterfaceTimingControl = pwdata[7:0];
            `PDW_IDX_MISC_CLK:   s_next.miscClockSelectConfig = pwdata[7:0];
            `PDW_IDX_PWD_SEL:    s_next.powerDownSelectRegister = {2'b00, pwdata[5:0]};
            `PDW_IDX_PWR_CTRL:   s_next.powerControlRegister = (s_reg.st == PDW_RUN) ? pwdata[7:0]
                                                                                  : s_reg.powerControlRegister;
            `PDW_IDX_IRQ_CFG:    s_next.irqConfig = {3'b000, pwdata[4:0]};
            `PDW_IDX_MAP_CTRL:   s_next.configWindowMapControl = pwdata[7:0];
            default:             s_next.rdErr = s_reg.rdErr;
         endcase
      end

      unique case (s_reg.st)
         PDW_RUN: begin
            if (s_next.powerControlRegister[`PDW_PD_BIT]) begin
               s_next.st             = PDW_DOWN;
               s_next.crystalBlocked = s_reg.powerDownSelectRegister[`PDW_SEL_CRYSTAL];
            end
         end
         PDW_DOWN: begin
            if (wakeAny) begin
               s_next.st                               = PDW_WAKE;
               s_next.powerControlRegister[`PDW_PD_BIT] = 1'b0;
               s_next.wakeSrc                          = {qualB, qualA};
               if (s_reg.crystalBlocked) begin
                  s_next.miscClockSelectConfig[`PDW_CLKSEL_BIT] = 1'b0;
               end
            end
         end
         PDW_WAKE: begin
            if (!wakeAny) begin
               s_next.st             = PDW_RUN;
               s_next.wakeIrq        = s_reg.wakeSrc;
               s_next.crystalBlocked = 1'b0;
            end
         end
         PDW_INIT: begin
            if (s_reg.initCnt == 16'h0000) begin
               s_next.st                                     = PDW_RUN;
               s_next.miscClockSelectConfig[`PDW_CLKSEL_BIT] = initCrystalSel;
               s_next.cpuRestart                             = 1'b1;
            end else begin
               s_next.initCnt = s_reg.initCnt - 16'h0001;
            end
         end
      endcase

      if (appReset && (s_reg.st != PDW_INIT)) begin
         s_next.st                   = PDW_RUN;
         s_next.powerControlRegister = `PDW_RST_PWR_CTRL;
         s_next.cpuRestart           = 1'b1;
         s_next.wakeIrq              = 2'b00;
         s_next.crystalBlocked       = 1'b0;
         if (s_reg.crystalBlocked) begin
            s_next.miscClockSelectConfig[`PDW_CLKSEL_BIT] = 1'b0;
         end
      end else if (watchdogReset && (s_reg.st == PDW_RUN || s_reg.st == PDW_WAKE)) begin
         s_next.st                   = PDW_RUN;
         s_next.powerControlRegister = `PDW_RST_PWR_CTRL;
         s_next.cpuRestart           = 1'b1;
         s_next.wakeIrq              = 2'b00;
         s_next.crystalBlocked       = 1'b0;
      end

      if (hardReset) begin
         s_next = RESET_VAL;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_reg <= RESET_VAL;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Clock switch
   // ----------------------------------------------------------------
   pdw_clk_switch u_switch (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .ringTick    (ringTick && ringOscEn),
      .crystalTick (crystalTick && crystalOscEn),
      .selCrystal  (s_reg.miscClockSelectConfig[`PDW_CLKSEL_BIT] && crystalOscEn),
      .freeze      (pdBlock && (s_reg.powerDownSelectRegister[`PDW_SEL_BUSCLK]
                                || s_reg.powerDownSelectRegister[`PDW_SEL_CRYSTAL])),
      .busClk      (busClk),
      .onCrystal   (onCrystal)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata        = s_reg.rdData;
   assign pslverr       = s_reg.rdErr;
   assign pready        = 1'b1;
   assign busOnCrystal  = onCrystal;
   // Oscillators stop only once the bus clock stands high
   assign ringOscEn     = !(pdBlock && s_reg.powerDownSelectRegister[`PDW_SEL_RING] && busClk);
   assign crystalOscEn  = !(pdBlock && s_reg.powerDownSelectRegister[`PDW_SEL_CRYSTAL] && busClk);
   assign logicClkBlock = pdBlock && s_reg.powerDownSelectRegister[`PDW_SEL_LOGICCLK];
   assign gbufPowerDown = pdBlock && s_reg.powerDownSelectRegister[`PDW_SEL_GBUF];
   assign pioPowerDown  = pdBlock && s_reg.powerDownSelectRegister[`PDW_SEL_PIO];
   assign memTiming     = s_reg.memoryInterfaceTimingControl;
   assign cpuHalt       = (s_reg.st != PDW_RUN);
   assign cpuRestart    = s_reg.cpuRestart;
   assign wakeIrqA      = s_reg.wakeIrq[0];
   assign wakeIrqB      = s_reg.wakeIrq[1];
   assign initBusy      = (s_reg.st == PDW_INIT);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic quiet;
   assign quiet = extResetN && !porFail && !appReset && !watchdogReset;

   sequence downIdle;
      (s_reg.st == PDW_DOWN) && !wakeAny && quiet && !extIrqA && !extIrqB;
   endsequence

   sequence wakeRelease;
      (s_reg.st == PDW_WAKE) && !wakeAny && quiet ##1 (s_reg.st == PDW_RUN) && (wakeIrqA || wakeIrqB);
   endsequence

   stayDown_a: assert property (downIdle |=> (s_reg.st == PDW_DOWN) && cpuHalt)
      else $error("left power-down without a wake event");

   extReset_a: assert property (!extResetN |=> initBusy && !s_reg.powerControlRegister[`PDW_PD_BIT]
                                 && !s_reg.miscClockSelectConfig[`PDW_CLKSEL_BIT])
      else $error("external reset did not restart initialization");

   watchdogIgnored_a: assert property ((s_reg.st == PDW_DOWN) && watchdogReset && !wakeAny && extResetN
                                       && !porFail && !appReset |=> (s_reg.st == PDW_DOWN) && !cpuRestart)
      else $error("watchdog woke the device from power-down");

   powerFail_a: assert property (porFail |=> initBusy ##1 initBusy)
      else $error("power-fail reset not honoured");

   ringOnWake_a: assert property ((s_reg.st == PDW_DOWN) && s_reg.crystalBlocked && wakeAny && quiet
                                  |=> !s_reg.miscClockSelectConfig[`PDW_CLKSEL_BIT] && ringOscEn)
      else $error("crystal blocked but ring not selected on wake");

   appWake_a: assert property (appReset && !initBusy && extResetN && !porFail
                               |=> cpuRestart && !cpuHalt)
      else $error("application reset did not restart the processor");

   qualMask_a: assert property ((s_reg.st == PDW_DOWN) && quiet
                                && !s_reg.irqConfig[`PDW_IRQ_GLOBAL] |=> (s_reg.st == PDW_DOWN))
      else $error("wake taken with global enable clear");

   holdWake_a: assert property ((s_reg.st == PDW_WAKE) && wakeAny && quiet
                                |=> (s_reg.st == PDW_WAKE) && !wakeIrqA && !wakeIrqB)
      else $error("power-down exited before interrupt release");

   resumeIsr_a: assert property (wakeRelease |-> !cpuRestart ##1 !wakeIrqA && !wakeIrqB)
      else $error("wake service pulse malformed");

   pdClear_a: assert property ((s_reg.st == PDW_DOWN) && wakeAny && quiet
                               |-> ringOscEn && crystalOscEn ##1 !s_reg.powerControlRegister[`PDW_PD_BIT])
      else $error("power-down bit not cleared on wake");

   crystalBlock_a: assert property (pdBlock && s_reg.powerDownSelectRegister[`PDW_SEL_CRYSTAL]
                                    && busClk |-> !crystalOscEn ##1 busClk)
      else $error("bus clock not frozen high with crystal blocked");

endmodule // pdw_power_ctrl

`default_nettype wire

// File: verif/pdw_sideband_model.sv
// Behavioural model of the logic that drives the wake and application reset sidebands
`default_nettype none

module pdw_sideband_model (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   input  wire logic [7:0] hold,
   output logic            appReset,
   output logic            extIrqA,
   output logic            extIrqB,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] cnt_reg;
   logic [1:0] kind_reg;

   // ----------------------------------------------------------------
   // Sideband hold counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_reg  <= 8'h00;
         kind_reg <= 2'h0;
      end else if (go && cnt_reg == 8'h00) begin
         cnt_reg  <= (hold < 8'h02) ? 8'h02 : hold;
         kind_reg <= kind;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end

   // Lines drop low once the hold runs out
   assign busy     = (cnt_reg != 8'h00);
   assign extIrqA  = busy && kind_reg == 2'h0;
   assign extIrqB  = busy && kind_reg == 2'h1;
   assign appReset = busy && kind_reg == 2'h2;
endmodule // pdw_sideband_model

`default_nettype wire

// File: verif/test_power_down_wake_clock_select.sv
// Self-checking bench for the power-down wake and clock select block
`include "pdw_params.svh"
`default_nettype none

module test_power_down_wake_clock_select;
   timeunit 1ns;
   timeprecision 1ns;
   import pdw_pkg::*;

   logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
   logic        extResetN, porFail, watchdogReset, ringTick, crystalTick, initCrystalSel;
   logic        go, busy, appReset, extIrqA, extIrqB, busClk, busOnCrystal, ringOscEn;
   logic        crystalOscEn, cpuHalt, cpuRestart, wakeIrqA, wakeIrqB, initBusy;
   logic        logicClkBlock, gbufPowerDown, pioPowerDown;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [1:0]  kind;
   logic [7:0]  hold, tc, memTiming;
   int          n_fail, cmp_count;
   integer      seed;

   pdw_power_ctrl #(.INIT_CYCLES(4)) dut (.clk_sys, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .extResetN, .porFail, .watchdogReset, .appReset, .extIrqA, .extIrqB,
      .ringTick, .crystalTick, .initCrystalSel, .busClk, .busOnCrystal, .ringOscEn, .crystalOscEn,
      .logicClkBlock, .gbufPowerDown, .pioPowerDown, .memTiming, .cpuHalt, .cpuRestart,
      .wakeIrqA, .wakeIrqB, .initBusy);

   pdw_sideband_model partner (.clk_sys, .reset, .go, .kind, .hold, .appReset, .extIrqA, .extIrqB, .busy);

   // ----------------------------------------------------------------
   // Clock and oscillator ticks
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      tc          <= tc + 8'h01;
      ringTick    <= ~tc[0];
      crystalTick <= (tc % 3 == 0);
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask

   task automatic hang(input string nm);
      $display("BAD %s expected event seen timeout", nm);
      n_fail++;
      summarize();
   endtask

   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
      bit done;
      done = 0;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (int i = 0; i < 20 && !done; i++) begin
         @(posedge clk_sys);
         done = (pready === 1'b1);
      end
      if (!done) hang("pready");
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp, input logic ee);
      apb(1'b0, idx, 32'h0);
      chk(nm, exp, rd);
      chk({nm, " error"}, {31'h0, ee}, {31'h0, err});
   endtask

   // Waits: 0 restart pulse, 1 wake interrupt pulse, 2 running on crystal
   task automatic waitSig(input int which);
      bit hit;
      hit = 0;
      for (int i = 0; i < 300 && !hit; i++) begin
         @(posedge clk_sys);
         case (which)
            0: hit = (cpuRestart === 1'b1);
            1: hit = (wakeIrqA === 1'b1);
            default: hit = (busOnCrystal === 1'b1);
         endcase
      end
      if (!hit) hang("wait");
   endtask

   task automatic side(input logic [1:0] k, input logic [7:0] h);
      @(posedge clk_sys);
      chk("partner busy", 0, {31'h0, busy});
      go   <= 1'b1;
      kind <= k;
      hold <= h;
      @(posedge clk_sys);
      go   <= 1'b0;
   endtask

   task automatic powerDown();
      apb(1'b1, `PDW_IDX_PWR_CTRL, 32'h2);
      repeat (4) @(posedge clk_sys);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'hb852;
      n_fail = 0;
      cmp_count = 0;
      {reset, tc} = {1'b1, 8'h00};
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {extResetN, porFail, watchdogReset, initCrystalSel, go, kind, hold} = {1'b1, 14'h0};
      {ringTick, crystalTick} = 2'b00;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      chk("initBusy", 1, initBusy);
      chk("busClk", 1, busClk);
      waitSig(0);
      rchk("misc closed", `PDW_IDX_MISC_CLK, 0, 1'b1);
      apb(1'b1, `PDW_IDX_MAP_CTRL, 32'h0);
      rchk("misc", `PDW_IDX_MISC_CLK, 0, 1'b0);
      rchk("unmapped", 16'h0100, 0, 1'b1);
      repeat (4) begin
         d = $random(seed);
         apb(1'b1, `PDW_IDX_MEM_TIMING, d);
         rchk("timing", `PDW_IDX_MEM_TIMING, {24'h0, d[7:0]}, 1'b0);
         chk("memTiming", {24'h0, d[7:0]}, {24'h0, memTiming});
      end
      apb(1'b1, `PDW_IDX_MISC_CLK, 32'h1);
      waitSig(2);
      rchk("status", `PDW_IDX_STATUS, 32'h10, 1'b0);
      $display("test registers done");
      apb(1'b1, `PDW_IDX_PWD_SEL, 32'hFF);
      rchk("power_down_select_register", `PDW_IDX_PWD_SEL, 32'h3F, 1'b0);
      apb(1'b1, `PDW_IDX_IRQ_CFG, 32'h0D);
      powerDown();
      chk("halt down", 1, cpuHalt);
      chk("busClk frozen", 1, busClk);
      chk("ring off", 0, ringOscEn);
      chk("blocks down", 32'h7, {29'h0, logicClkBlock, gbufPowerDown, pioPowerDown});
      watchdogReset <= 1'b1;
      @(posedge clk_sys);
      watchdogReset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("watchdog halt", 1, cpuHalt);
      chk("watchdog init", 0, initBusy);
      side(2'h1, 8'h04);
      repeat (6) @(posedge clk_sys);
      chk("irqB ignored", 1, cpuHalt);
      side(2'h0, 8'h04);
      @(posedge clk_sys);
      chk("osc restart", 1, ringOscEn);
      @(posedge clk_sys);
      chk("held halted", 1, cpuHalt);
      waitSig(1);
      chk("resumed", 0, cpuHalt);
      chk("blocks up", 0, {29'h0, logicClkBlock, gbufPowerDown, pioPowerDown});
      rchk("pd bit", `PDW_IDX_PWR_CTRL, 0, 1'b0);
      repeat (10) @(posedge clk_sys);
      chk("on ring", 0, busOnCrystal);
      apb(1'b1, `PDW_IDX_MISC_CLK, 32'h1);
      waitSig(2);
      $display("test interrupt wake done");
      powerDown();
      side(2'h2, 8'h02);
      waitSig(0);
      rchk("misc app", `PDW_IDX_MISC_CLK, 0, 1'b0);
      $display("test application reset done");
      powerDown();
      initCrystalSel <= 1'b1;
      extResetN <= 1'b0;
      repeat (2) @(posedge clk_sys);
      extResetN <= 1'b1;
      @(posedge clk_sys);
      chk("ext init", 1, initBusy);
      waitSig(0);
      rchk("map reset", `PDW_IDX_MAP_CTRL, 1, 1'b0);
      waitSig(2);
      $display("test external reset done");
      powerDown();
      porFail <= 1'b1;
      @(posedge clk_sys);
      porFail <= 1'b0;
      @(posedge clk_sys);
      chk("por init", 1, initBusy);
      waitSig(0);
      $display("test power fail done");
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      hang("run");
   end
endmodule // test_power_down_wake_clock_select

`default_nettype wire
